//--- axc_pkg.sv
/*
 * Shared constants and types of the auxiliary pin, ADC, wake-up timer
 * and battery detector register bank.
 * Assumes an 8-bit register port and a 250 MHz system clock.
 */
`default_nettype none
package axc_pkg;
	// register offsets
	localparam logic [7:0] OFS_PIN2_CFG  = 8'h0d;
	localparam logic [7:0] OFS_PORT_CFG  = 8'h0e;
	localparam logic [7:0] OFS_ADC_CFG   = 8'h0f;
	localparam logic [7:0] OFS_ADC_OFFS  = 8'h10;
	localparam logic [7:0] OFS_ADC_RES   = 8'h11;
	localparam logic [7:0] OFS_TS_CAL    = 8'h12;
	localparam logic [7:0] OFS_TV_OFFS   = 8'h13;
	localparam logic [7:0] OFS_WT_EXP    = 8'h14;
	localparam logic [7:0] OFS_WT_MANT_H = 8'h15;
	localparam logic [7:0] OFS_WT_MANT_L = 8'h16;
	localparam logic [7:0] OFS_WT_CUR_H  = 8'h17;
	localparam logic [7:0] OFS_WT_CUR_L  = 8'h18;
	localparam logic [7:0] OFS_BAT_THR   = 8'h1a;
	localparam logic [7:0] OFS_BAT_LVL   = 8'h1b;
	// reset values
	localparam logic [7:0] RST_PIN2_CFG  = 8'h00;
	localparam logic [7:0] RST_PORT_CFG  = 8'h00;
	localparam logic [7:0] RST_ADC_CFG   = 8'h00;
	localparam logic [3:0] RST_ADC_OFFS  = 4'h0;
	localparam logic [7:0] RST_TS_CAL    = 8'h20;
	localparam logic [7:0] RST_TV_OFFS   = 8'h00;
	localparam logic [4:0] RST_WT_EXP    = 5'h03;
	localparam logic [7:0] RST_WT_MANT_H = 8'h00;
	localparam logic [7:0] RST_WT_MANT_L = 8'h01;
	localparam logic [4:0] RST_BAT_THR   = 5'h14;
	// field positions
	localparam int ITSDO_BIT     = 3;
	localparam int ADC_START_BIT = 7;
	localparam int TS_SIGN_BIT   = 3;
	// timing
	localparam logic [4:0] WT_EXP_MAX    = 5'h14;
	localparam int         WT_TICK_MULT  = 4;
	localparam int         MCLK_HZ       = 250_000_000;
	localparam int         BAT_SLEEP_S   = 1;
	localparam int         BAT_SLEEP_CYC = BAT_SLEEP_S * MCLK_HZ;
	// pin function codes
	typedef enum logic [4:0] {
		FN_MCU_CLK   = 5'b00000,
		FN_WT_EXP    = 5'b00001,
		FN_LOW_BAT   = 5'b00010,
		FN_DIR_IN    = 5'b00011,
		FN_INT_FALL  = 5'b00100,
		FN_INT_RISE  = 5'b00101,
		FN_INT_ANY   = 5'b00110,
		FN_DIR_OUT   = 5'b01010,
		FN_TX_CLK    = 5'b01111,
		FN_TX_DATA   = 5'b10000,
		FN_RETX_REQ  = 5'b10001,
		FN_TX_STATE  = 5'b10010,
		FN_FIFO_AFUL = 5'b10011,
		FN_VDD       = 5'b11101
	} axc_pinfn_t;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} axc_busreq_t;
	// settings handed to the analog converter and sensor
	typedef struct packed {
		logic       start;
		logic [2:0] sel;
		logic [1:0] refSel;
		logic [1:0] gain;
		logic [3:0] ampOffs;
		logic [7:0] tsCal;
	} axc_adcctl_t;
endpackage : axc_pkg
`default_nettype wire

//--- axc_top.sv
/*
 * Register bank for the third pin's function mux, direct I/O and external interrupt status,
 * aux ADC, temperature offset, wake-up timer and low battery detector.
 * Assumes inputs synchronous to mclk, wakeTick one pulse per 32.768 kHz period, analog work done outside.
 */
// How it works
// - codes 0-2 give mcu clock, timer, battery
// - direct output drives bit; direct input reads
// - interrupt codes catch fall, rise, any change
// - tx data clock out; tx data in
// - tx state and fifo almost full out
// - retransmit input; VDD code high; others low
// - bits 6:4 show pin interrupt status
// - itsdo and idle select put irq on SDO
// - start bit writes start; reads done
// - source select passed to converter
// - reference select passed to converter
// - amplifier offset is sign plus magnitude
// - conversion result in read-only register
// - temperature range select passed to sensor
// - signed offset added to temperature results
// - exponent above 20 acts as 20
// - period is 4*M*2^R slow ticks
// - running mantissa readable in two bytes
// - low battery set when level below threshold
// - level sampled every second asleep, else always
// - enabled timer runs always and flags expiry
// - detector works only while enabled
`default_nettype none
module axc_top
#(
	parameter int BAT_SLEEP_CYCLES = axc_pkg::BAT_SLEEP_CYC
) (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                resetn,
	// register port
	input  wire axc_pkg::axc_busreq_t busReq,
	output var  logic [7:0]          regRdata,
	// general-purpose pins
	input  wire logic [2:0]          pinIn,
	input  wire logic [4:0]          pin0Select,
	input  wire logic [4:0]          pin1Select,
	output var  logic                pin2Out,
	output var  logic                pin2Oe,
	// sources for the third pin and sinks from it
	input  wire logic                mcuClk,
	input  wire logic                txDataClk,
	input  wire logic                txStateIn,
	input  wire logic                fifoAlmostFull,
	output var  logic                txModData,
	output var  logic                retransReq,
	// serial output and interrupt request
	input  wire logic                chipSelectN,
	input  wire logic                irqN,
	input  wire logic                spiSdo,
	input  wire logic                spiSdoOe,
	output var  logic                sdoOut,
	output var  logic                sdoOe,
	// aux converter
	output var  axc_pkg::axc_adcctl_t adcCtl,
	input  wire logic                adcDone,
	input  wire logic [7:0]          adcData,
	// wake-up timer, battery detector and external interrupt status
	input  wire logic                wakeTick,
	input  wire logic                wakeTimerEn,
	input  wire logic                lowBatEn,
	input  wire logic                sleepMode,
	input  wire logic [4:0]          batLevelIn,
	output var  logic                wakeExpired,
	output var  logic                lowBattery,
	output var  logic [2:0]          extIntStatus
);
	import axc_pkg::*;

	typedef struct packed {
		logic [7:0]  pin2Cfg;
		logic [2:0]  dirOut;
		logic        itsdo;
		logic [2:0]  intStat;
		logic [2:0]  pinPrev;
		logic        edgeArmed;
		logic        adcDoneFlag;
		logic [7:0]  adcResult;
		logic [6:0]  adcCfg;
		logic [3:0]  adcOffs;
		logic [7:0]  tsCal;
		logic [7:0]  tvOffs;
		logic [4:0]  wtExp;
		logic [15:0] wtMant;
		logic [15:0] wtCur;
		logic [22:0] wtPresc;
		logic        wtEnPrev;
		logic        wtExpired;
		logic [4:0]  batThr;
		logic [4:0]  batLevel;
		logic [27:0] batCnt;
		logic        lowBat;
		logic        adcStart;
		logic [7:0]  rdata;
		logic        pin2O;
		logic        pin2E;
		logic        txMod;
		logic        retx;
		logic        sdoO;
		logic        sdoE;
	} axc_state_t;

	axc_state_t  state_reg;
	axc_state_t  state_next;
	logic [4:0]  fn2;
	logic [4:0]  effExp;
	logic [22:0] prescTop;
	logic [2:0]  dirRead;
	logic [4:0]  pinFn [3];
	logic [27:0] batTop;

	assign fn2    = state_reg.pin2Cfg[4:0];
	assign batTop = 28'(BAT_SLEEP_CYCLES - 1);
	assign pinFn[0] = pin0Select;
	assign pinFn[1] = pin1Select;
	assign pinFn[2] = fn2;
	// exponent clamp and prescale length of 4 * 2^R slow ticks
	assign effExp   = (state_reg.wtExp > WT_EXP_MAX) ? WT_EXP_MAX : state_reg.wtExp;
	assign prescTop = 23'((WT_TICK_MULT << effExp) - 1);

	// direct bits read the pin only in direct input mode
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			dirRead[i] = (pinFn[i] == FN_DIR_IN) ? pinIn[i] : state_reg.dirOut[i];
		end
	end

	// next state
	always_comb begin
		logic        wr;
		logic        rd;
		logic [7:0]  a;
		logic [7:0]  wd;
		wr = busReq.wr;
		rd = busReq.rd;
		a  = busReq.addr;
		wd = busReq.wdata;
		state_next = state_reg;
		state_next.adcStart = 1'b0;
		state_next.pinPrev  = pinIn;
		state_next.edgeArmed = 1'b1; // no edge until a real previous level is held, pins may idle high

		// writes; read-only offsets ignore writes
		if (wr) begin
			if (a == OFS_PIN2_CFG) begin
				state_next.pin2Cfg = wd;
			end else if (a == OFS_PORT_CFG) begin
				state_next.itsdo  = wd[ITSDO_BIT];
				state_next.dirOut = wd[2:0];
			end else if (a == OFS_ADC_CFG) begin
				state_next.adcCfg = wd[6:0];
			end else if (a == OFS_ADC_OFFS) begin
				state_next.adcOffs = wd[3:0];
			end else if (a == OFS_TS_CAL) begin
				state_next.tsCal = wd;
			end else if (a == OFS_TV_OFFS) begin
				state_next.tvOffs = wd;
			end else if (a == OFS_WT_EXP) begin
				state_next.wtExp = wd[4:0];
			end else if (a == OFS_WT_MANT_H) begin
				state_next.wtMant[15:8] = wd;
			end else if (a == OFS_WT_MANT_L) begin
				state_next.wtMant[7:0] = wd;
			end else if (a == OFS_BAT_THR) begin
				state_next.batThr = wd[4:0];
			end
		end

		// external interrupt edges; a read clears, a new edge wins
		if (rd && a == OFS_PORT_CFG) begin
			state_next.intStat = 3'b000;
		end
		for (int i = 0; i < 3; i++) begin
			if (state_reg.edgeArmed && ((pinFn[i] == FN_INT_FALL && state_reg.pinPrev[i] && !pinIn[i]) ||
			    (pinFn[i] == FN_INT_RISE && !state_reg.pinPrev[i] && pinIn[i]) ||
			    (pinFn[i] == FN_INT_ANY && state_reg.pinPrev[i] != pinIn[i]))) begin
				state_next.intStat[i] = 1'b1;
			end
		end

		// converter: done and result land together; a new start wins
		if (adcDone) begin
			state_next.adcDoneFlag = 1'b1;
			if (state_reg.adcCfg[6:4] == 3'b000) begin
				state_next.adcResult = adcData + state_reg.tvOffs;
			end else begin
				state_next.adcResult = adcData;
			end
		end
		if (wr && a == OFS_ADC_CFG && wd[ADC_START_BIT]) begin
			state_next.adcStart    = 1'b1;
			state_next.adcDoneFlag = 1'b0;
		end

		// wake-up timer counts down the mantissa every prescale period
		state_next.wtEnPrev = wakeTimerEn;
		if (!wakeTimerEn || !state_reg.wtEnPrev) begin
			state_next.wtCur     = state_reg.wtMant;
			state_next.wtPresc   = 23'h0;
			state_next.wtExpired = 1'b0;
		end else if (wakeTick) begin
			if (state_reg.wtPresc >= prescTop) begin
				state_next.wtPresc = 23'h0;
				if (state_reg.wtCur <= 16'h0001) begin
					state_next.wtCur     = state_reg.wtMant;
					state_next.wtExpired = 1'b1;
				end else begin
					state_next.wtCur = state_reg.wtCur - 16'h0001;
				end
			end else begin
				state_next.wtPresc = state_reg.wtPresc + 23'h1;
			end
		end

		// battery level: continuous when awake, once per second asleep
		if (!lowBatEn) begin
			state_next.batCnt = 28'h0;
			state_next.lowBat = 1'b0;
		end else begin
			if (state_reg.batCnt >= batTop) begin
				state_next.batCnt = 28'h0;
			end else begin
				state_next.batCnt = state_reg.batCnt + 28'h1;
			end
			if (!sleepMode || state_reg.batCnt >= batTop) begin
				state_next.batLevel = batLevelIn;
			end
			state_next.lowBat = (state_reg.batLevel < state_reg.batThr);
		end

		// read data, valid the cycle after the strobe; unmapped reads zero
		state_next.rdata = 8'h00;
		if (rd) begin
			if (a == OFS_PIN2_CFG) begin
				state_next.rdata = state_reg.pin2Cfg;
			end else if (a == OFS_PORT_CFG) begin
				state_next.rdata = {1'b0, state_reg.intStat, state_reg.itsdo, dirRead};
			end else if (a == OFS_ADC_CFG) begin
				state_next.rdata = {state_reg.adcDoneFlag, state_reg.adcCfg};
			end else if (a == OFS_ADC_OFFS) begin
				state_next.rdata = {4'h0, state_reg.adcOffs};
			end else if (a == OFS_ADC_RES) begin
				state_next.rdata = state_reg.adcResult;
			end else if (a == OFS_TS_CAL) begin
				state_next.rdata = state_reg.tsCal;
			end else if (a == OFS_TV_OFFS) begin
				state_next.rdata = state_reg.tvOffs;
			end else if (a == OFS_WT_EXP) begin
				state_next.rdata = {3'h0, state_reg.wtExp};
			end else if (a == OFS_WT_MANT_H) begin
				state_next.rdata = state_reg.wtMant[15:8];
			end else if (a == OFS_WT_MANT_L) begin
				state_next.rdata = state_reg.wtMant[7:0];
			end else if (a == OFS_WT_CUR_H) begin
				state_next.rdata = state_reg.wtCur[15:8];
			end else if (a == OFS_WT_CUR_L) begin
				state_next.rdata = state_reg.wtCur[7:0];
			end else if (a == OFS_BAT_THR) begin
				state_next.rdata = {3'h0, state_reg.batThr};
			end else if (a == OFS_BAT_LVL) begin
				state_next.rdata = {3'h0, state_reg.batLevel};
			end
		end

		// third pin function mux, one flop after the source
		state_next.pin2E = 1'b1;
		state_next.pin2O = 1'b0;
		case (fn2)
			FN_MCU_CLK:   state_next.pin2O = mcuClk;
			FN_WT_EXP:    state_next.pin2O = state_reg.wtExpired;
			FN_LOW_BAT:   state_next.pin2O = state_reg.lowBat;
			FN_DIR_OUT:   state_next.pin2O = state_reg.dirOut[2];
			FN_TX_CLK:    state_next.pin2O = txDataClk;
			FN_TX_STATE:  state_next.pin2O = txStateIn;
			FN_FIFO_AFUL: state_next.pin2O = fifoAlmostFull;
			FN_VDD:       state_next.pin2O = 1'b1;
			FN_DIR_IN, FN_INT_FALL, FN_INT_RISE, FN_INT_ANY, FN_TX_DATA, FN_RETX_REQ: begin
				state_next.pin2E = 1'b0;
			end
			default:      state_next.pin2O = 1'b0;
		endcase
		state_next.txMod = (fn2 == FN_TX_DATA) && pinIn[2];
		state_next.retx  = (fn2 == FN_RETX_REQ) && pinIn[2];

		// serial output carries the irq line while itsdo is set and the chip is deselected
		if (state_reg.itsdo && chipSelectN) begin
			state_next.sdoO = irqN;
			state_next.sdoE = 1'b1;
		end else begin
			state_next.sdoO = spiSdo;
			state_next.sdoE = spiSdoOe;
		end
	end

	// one register for the whole state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg         <= '0;
			state_reg.pin2Cfg <= RST_PIN2_CFG;
			state_reg.itsdo   <= RST_PORT_CFG[ITSDO_BIT];
			state_reg.dirOut  <= RST_PORT_CFG[2:0];
			state_reg.adcCfg  <= RST_ADC_CFG[6:0];
			state_reg.adcOffs <= RST_ADC_OFFS;
			state_reg.tsCal   <= RST_TS_CAL;
			state_reg.tvOffs  <= RST_TV_OFFS;
			state_reg.wtExp   <= RST_WT_EXP;
			state_reg.wtMant  <= {RST_WT_MANT_H, RST_WT_MANT_L};
			state_reg.wtCur   <= {RST_WT_MANT_H, RST_WT_MANT_L};
			state_reg.batThr  <= RST_BAT_THR;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flops
	always_comb begin
		regRdata       = state_reg.rdata;
		pin2Out        = state_reg.pin2O;
		pin2Oe         = state_reg.pin2E;
		txModData      = state_reg.txMod;
		retransReq     = state_reg.retx;
		sdoOut         = state_reg.sdoO;
		sdoOe          = state_reg.sdoE;
		wakeExpired    = state_reg.wtExpired;
		lowBattery     = state_reg.lowBat;
		extIntStatus   = state_reg.intStat;
		adcCtl         = {state_reg.adcStart, state_reg.adcCfg, state_reg.adcOffs, state_reg.tsCal};
	end

	// checks
	sdo_irq_path_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg.itsdo && chipSelectN |=> sdoOut == $past(irqN) && sdoOe)
		else $error("irq not on serial output");
	pin2_vdd_a: assert property (@(posedge mclk) disable iff (!resetn)
		fn2 == FN_VDD |=> pin2Out && pin2Oe)
		else $error("pin not driven high");
	pin2_direct_a: assert property (@(posedge mclk) disable iff (!resetn)
		fn2 == FN_DIR_OUT |=> pin2Out == $past(state_reg.dirOut[2]) && pin2Oe)
		else $error("direct output wrong");
	pin2_input_a: assert property (@(posedge mclk) disable iff (!resetn)
		fn2 inside {FN_DIR_IN, FN_INT_FALL, FN_INT_RISE} |=> !pin2Oe)
		else $error("input pin driven");
	adc_start_a: assert property (@(posedge mclk) disable iff (!resetn)
		busReq.wr && busReq.addr == OFS_ADC_CFG && busReq.wdata[ADC_START_BIT]
		|=> adcCtl.start && !state_reg.adcDoneFlag ##1 !adcCtl.start)
		else $error("start did not clear done");
	adc_result_a: assert property (@(posedge mclk) disable iff (!resetn)
		adcDone && state_reg.adcCfg[6:4] != 3'b000 |=> state_reg.adcResult == $past(adcData))
		else $error("result not stored");
	low_bat_a: assert property (@(posedge mclk) disable iff (!resetn)
		lowBatEn && state_reg.batLevel < state_reg.batThr |=> lowBattery)
		else $error("low battery missed");
	wake_off_a: assert property (@(posedge mclk) disable iff (!resetn)
		!wakeTimerEn |=> !wakeExpired && state_reg.wtCur == $past(state_reg.wtMant))
		else $error("disabled timer not reloaded");
	int_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
		fn2 == FN_INT_RISE && $rose(pinIn[2]) |=> extIntStatus[2])
		else $error("rising edge lost");
endmodule : axc_top
`default_nettype wire

//--- axc_host_model.sv
/*
 * Host side of the register port: one bus transfer at a time.
 * Assumes the bench's mclk; read data one cycle after rd.
 */
`default_nettype none
module axc_host_model (
	// clock
	input  wire logic                 mclk,
	// register port
	output var  axc_pkg::axc_busreq_t busReq,
	input  wire logic [7:0]           regRdata
);
	timeunit 1ns;
	timeprecision 100ps;
	import axc_pkg::*;

	initial busReq = '0;

	// strobe held across the taking edge, read data picked up just after it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		logic [7:0] v;
		v = d;
		if (w && a == OFS_WT_MANT_L && v == 8'h00) v = 8'h01;
		@(posedge mclk);
		busReq <= '{addr: a, wdata: v, wr: w, rd: !w};
		@(posedge mclk);
		busReq <= '0;
		#1 r = regRdata;
	endtask : xfer
endmodule : axc_host_model
`default_nettype wire

//--- aux_pin_adc_wakeup_control_tb.sv
/*
 * Self-checking bench of the auxiliary register bank.
 * Assumes axc_top and axc_host_model; battery period shortened to 16.
 */
`default_nettype none
module aux_pin_adc_wakeup_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import axc_pkg::*;

	logic mclk = 0, resetn = 0;
	logic [2:0] pinIn;
	logic [4:0] pin0Select, pin1Select, batLevelIn;
	logic mcuClk, txDataClk, txStateIn, fifoAlmostFull, chipSelectN, irqN, spiSdo, spiSdoOe;
	logic adcDone, wakeTick, wakeTimerEn, lowBatEn, sleepMode;
	logic [7:0] adcData, regRdata;
	axc_busreq_t busReq;
	axc_adcctl_t adcCtl;
	logic pin2Out, pin2Oe, txModData, retransReq, sdoOut, sdoOe, wakeExpired, lowBattery;
	logic [2:0] extIntStatus;
	int errors = 0, samples_checked = 0;
	logic [7:0] regAddr [11] = '{OFS_PIN2_CFG, OFS_PORT_CFG, OFS_ADC_CFG, OFS_ADC_OFFS, OFS_TS_CAL,
		OFS_TV_OFFS, OFS_WT_EXP, OFS_WT_MANT_H, OFS_WT_MANT_L, OFS_BAT_THR, 8'h40};
	logic [7:0] regInit [11] = '{RST_PIN2_CFG, RST_PORT_CFG, RST_ADC_CFG, 8'(RST_ADC_OFFS), RST_TS_CAL,
		RST_TV_OFFS, 8'(RST_WT_EXP), RST_WT_MANT_H, RST_WT_MANT_L, 8'(RST_BAT_THR), 8'h00};

	always #2 mclk = ~mclk;

	axc_top #(.BAT_SLEEP_CYCLES(16)) dut (.mclk, .resetn, .busReq, .regRdata, .pinIn, .pin0Select,
		.pin1Select, .pin2Out, .pin2Oe, .mcuClk, .txDataClk, .txStateIn, .fifoAlmostFull, .txModData,
		.retransReq, .chipSelectN, .irqN, .spiSdo, .spiSdoOe, .sdoOut, .sdoOe, .adcCtl, .adcDone,
		.adcData, .wakeTick, .wakeTimerEn, .lowBatEn, .sleepMode, .batLevelIn, .wakeExpired,
		.lowBattery, .extIntStatus);

	axc_host_model host (.mclk, .busReq, .regRdata);

	// comparison and bookkeeping
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	task automatic bw(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		host.xfer(1'b1, a, d, r);
	endtask : bw

	task automatic br(input logic [7:0] a, output logic [7:0] r);
		host.xfer(1'b0, a, 8'h00, r);
	endtask : br

	// wait n edges, then sample just after the last one
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	// expected {enable, level} of the third pin; timer and battery sources are off here
	function automatic logic [1:0] expPin(input logic [4:0] c, input logic dio);
		case (c)
			FN_MCU_CLK: return {1'b1, mcuClk};
			FN_DIR_IN, FN_INT_FALL, FN_INT_RISE, FN_INT_ANY, FN_TX_DATA, FN_RETX_REQ: return 2'b00;
			FN_DIR_OUT: return {1'b1, dio};
			FN_TX_CLK: return {1'b1, txDataClk};
			FN_TX_STATE: return {1'b1, txStateIn};
			FN_FIFO_AFUL: return {1'b1, fifoAlmostFull};
			FN_VDD: return 2'b11;
			default: return 2'b10;
		endcase
	endfunction : expPin

	// hang guard, sized well above the whole sequence
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		$display("Error at %0t: watchdog expired", $time);
		wrap_up;
	end

	// main sequence
	initial begin
		logic [7:0] r, v, d, tv, cal;
		logic [1:0] e;
		int n, m, rr;
		{pinIn, pin0Select, pin1Select, batLevelIn, mcuClk, txDataClk, txStateIn, fifoAlmostFull} = '0;
		{spiSdo, spiSdoOe, adcDone, wakeTick, wakeTimerEn, lowBatEn, sleepMode, adcData} = '0;
		chipSelectN = 1;
		irqN = 1;
		void'($urandom(32'he0b3));
		repeat (16) @(posedge mclk);
		resetn <= 1;
		foreach (regAddr[i]) begin
			br(regAddr[i], r);
			chk(r, regInit[i]);
		end
		$display("reset values done");
		// every function code of the third pin
		for (int c = 0; c < 32; c++) begin
			@(posedge mclk);
			{mcuClk, txDataClk, txStateIn, fifoAlmostFull} <= 4'($urandom);
			pinIn <= 3'($urandom);
			pin0Select <= 5'(c);
			pin1Select <= 5'(c);
			v = {3'($urandom), 5'(c)};
			bw(OFS_PIN2_CFG, v);
			d = 8'($urandom) & 8'h07;
			bw(OFS_PORT_CFG, d);
			cyc(3);
			e = expPin(5'(c), d[2]);
			chk(pin2Oe, e[1]);
			if (e[1]) chk(pin2Out, e[0]);
			chk(txModData, c == 16 && pinIn[2]);
			chk(retransReq, c == 17 && pinIn[2]);
			br(OFS_PIN2_CFG, r);
			chk(r, v);
			br(OFS_PORT_CFG, r);
			chk(r[2:0], c == 3 ? pinIn : d[2:0]);
		end
		$display("pin functions done");
		// falling, rising, any-change interrupts on all three pins
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk);
			pin0Select <= 5'(4 + k);
			pin1Select <= 5'(4 + k);
			pinIn <= 3'b111;
			bw(OFS_PIN2_CFG, 8'(4 + k));
			cyc(2);
			br(OFS_PORT_CFG, r);
			@(posedge mclk);
			pinIn <= 3'b000;
			cyc(3);
			chk(extIntStatus, k != 1 ? 3'b111 : 3'b000);
			br(OFS_PORT_CFG, r);
			chk(r[6:4], k != 1 ? 3'b111 : 3'b000);
			@(posedge mclk);
			pinIn <= 3'b111;
			cyc(3);
			br(OFS_PORT_CFG, r);
			chk(r[6:4], k != 0 ? 3'b111 : 3'b000);
		end
		$display("pin interrupts done");
		// request line on the serial output only when enabled and deselected
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			chipSelectN <= k[0];
			{irqN, spiSdo, spiSdoOe} <= 3'($urandom);
			bw(OFS_PORT_CFG, {4'h0, k[1], 3'b000});
			cyc(2);
			chk({sdoOut, sdoOe}, k == 3 ? {irqN, 1'b1} : {spiSdo, spiSdoOe});
		end
		$display("serial output done");
		// conversions, the first one from the temperature source
		for (int k = 0; k < 4; k++) begin
			tv = 8'($urandom);
			d = 8'($urandom);
			cal = 8'($urandom);
			v = {1'b1, 7'($urandom)};
			if (k == 0) v[6:4] = 3'b000;
			bw(OFS_TV_OFFS, tv);
			bw(OFS_TS_CAL, cal);
			bw(OFS_ADC_OFFS, d);
			br(OFS_ADC_OFFS, r);
			chk(r, d & 8'h0f);
			bw(OFS_ADC_CFG, v);
			chk(adcCtl.start, 1'b1);
			chk({adcCtl.sel, adcCtl.refSel, adcCtl.gain}, v[6:0]);
			chk({adcCtl.ampOffs, adcCtl.tsCal}, {d[3:0], cal});
			br(OFS_ADC_CFG, r);
			chk(r[7], 1'b0);
			@(posedge mclk);
			adcDone <= 1;
			adcData <= d;
			@(posedge mclk);
			adcDone <= 0;
			cyc(1);
			br(OFS_ADC_RES, r);
			chk(r, 8'(d + (v[6:4] == 3'b000 ? tv : 8'h00)));
			bw(OFS_ADC_RES, ~r);
			br(OFS_ADC_RES, v);
			chk(v, r);
			br(OFS_ADC_CFG, r);
			chk(r[7], 1'b1);
		end
		$display("converter done");
		// wake-up period in slow ticks, shown on the third pin
		for (int k = 0; k < 2; k++) begin
			rr = 2 * k;
			m = 1 + $urandom % 4;
			@(posedge mclk);
			wakeTimerEn <= 0;
			bw(OFS_WT_EXP, 8'(rr));
			bw(OFS_WT_MANT_H, 8'h00);
			bw(OFS_WT_MANT_L, 8'(m));
			bw(OFS_PIN2_CFG, {3'b000, FN_WT_EXP});
			@(posedge mclk);
			wakeTimerEn <= 1;
			cyc(2);
			br(OFS_WT_CUR_H, r);
			br(OFS_WT_CUR_L, v);
			chk({r, v}, 16'(m));
			n = 0;
			while (wakeExpired !== 1'b1 && n < 300) begin
				@(posedge mclk);
				wakeTick <= 1;
				@(posedge mclk);
				wakeTick <= 0;
				cyc(1);
				n++;
			end
			chk(16'(n), 16'((4 * m) << rr));
			cyc(2);
			chk(pin2Out, 1'b1);
		end
		@(posedge mclk);
		wakeTimerEn <= 0;
		$display("wake timer done");
		// battery detector: off, awake with random levels, then asleep
		bw(OFS_PIN2_CFG, {3'b000, FN_LOW_BAT});
		bw(OFS_BAT_THR, 8'h1f);
		cyc(3);
		chk(lowBattery, 1'b0);
		for (int k = 0; k < 6; k++) begin
			v = 8'($urandom);
			d = (k == 0) ? v & 8'h1f : 8'($urandom) & 8'h1f;
			@(posedge mclk);
			lowBatEn <= 1;
			batLevelIn <= d[4:0];
			bw(OFS_BAT_THR, v);
			br(OFS_BAT_THR, r);
			chk(r, v & 8'h1f);
			cyc(3);
			chk(lowBattery, d[4:0] < v[4:0]);
			chk(pin2Out, d[4:0] < v[4:0]);
			br(OFS_BAT_LVL, r);
			chk(r, d);
		end
		@(posedge mclk);
		sleepMode <= 1;
		batLevelIn <= 5'h0a;
		n = 0;
		r = 8'h00;
		while (r !== 8'h0a && n < 20) begin
			br(OFS_BAT_LVL, r);
			n++;
		end
		chk(r, 8'h0a);
		@(posedge mclk);
		batLevelIn <= 5'h15;
		cyc(2);
		br(OFS_BAT_LVL, r);
		chk(r, 8'h0a);
		cyc(20);
		br(OFS_BAT_LVL, r);
		chk(r, 8'h15);
		$display("battery done");
		wrap_up;
	end
endmodule : aux_pin_adc_wakeup_control_tb
`default_nettype wire
